// *** dtc_ctrl.sv ***
`timescale 1ns/1ps
// Function
// - only buffer mode select zero starts packets
// - expansion bus transfers: no bounds abort
// - zero count still performs one transfer
// - read-only writes blocked, no illegal flag
// - switch size sets burst before arbitration
// - chaining does one extra transfer previous channel
module dtc_ctrl
    import dtc_pkg::*;
#(
    parameter int NCHAN = NCH
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [NCHAN-1:0] pkt_enable,
    input wire logic [NCHAN-1:0] pkt_request,
    input wire logic [NCHAN-1:0] pkt_chain,
    input wire logic [NCHAN-1:0] pkt_exp_bus,
    input wire logic [NCHAN*CNT_W-1:0] pkt_count,
    input wire logic [NCHAN*SW_W-1:0] pkt_switch,
    input wire logic [NCHAN*ADDR_W-1:0] pkt_src,
    input wire logic [NCHAN*ADDR_W-1:0] pkt_dst,
    input wire logic buffer_mode_select_setting,
    input wire logic halt,
    input wire logic stop,
    output logic rd_req,
    output logic [ADDR_W-1:0] rd_addr,
    input wire logic rd_ack,
    input wire logic [DATA_W-1:0] rd_data,
    output logic wr_req,
    output logic [ADDR_W-1:0] wr_addr,
    output logic [DATA_W-1:0] wr_data,
    output logic wr_cs,
    input wire logic wr_ack,
    input wire logic dst_read_only,
    output logic illegal_access,
    output logic abort,
    output logic busy,
    output logic [NCHAN-1:0] pkt_done
);
    localparam int CW = $clog2(NCHAN) > 0 ? $clog2(NCHAN) : 1;
    dtc_state_t st_reg, st_next;
    logic [CW-1:0] ch_reg, ch_next;
    logic [CNT_W-1:0] cnt_reg [NCHAN];
    logic [CNT_W-1:0] cnt_next [NCHAN];
    logic [NCHAN-1:0] act_reg, act_next;
    logic [SW_W:0] burst_reg, burst_next;
    logic extra_reg, extra_next;
    logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next, wr_addr_reg, wr_addr_next;
    // per-channel pointers, so a channel resumes where it stopped after losing arbitration
    logic [ADDR_W-1:0] src_reg [NCHAN];
    logic [ADDR_W-1:0] src_next [NCHAN];
    logic [ADDR_W-1:0] dst_reg [NCHAN];
    logic [ADDR_W-1:0] dst_next [NCHAN];
    logic ext_reg, ext_next;
    logic rd_req_reg, wr_req_reg, wr_cs_reg, busy_reg;
    logic [NCHAN-1:0] done_reg, done_next;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [DATA_W-1:0] f_out_data;
    logic [NCHAN-1:0] start;
    logic [CW-1:0] pick;
    logic pick_ok;

    // read data waits in the fifo; a full fifo holds off the read side
    dtc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_b(rst_b),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(rd_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // lowest channel index wins arbitration
    always_comb begin
        pick = '0;
        pick_ok = 1'b0;
        for (int i = NCHAN - 1; i >= 0; i--) begin
            if (act_reg[i] && pkt_request[i]) begin
                pick = CW'(i);
                pick_ok = 1'b1;
            end
        end
    end

    // burst length before arbitration, per channel bus
    function automatic logic [SW_W:0] burst_len(input logic [SW_W-1:0] sw, input logic exp);
        if (exp || sw == SW_ZERO) begin
            burst_len = {1'b0, sw} + 1'b1;
        end else begin
            burst_len = {1'b0, sw};
        end
    endfunction

    // packet state and transfer engine
    always_comb begin
        st_next = st_reg;
        ch_next = ch_reg;
        act_next = act_reg;
        burst_next = burst_reg;
        extra_next = extra_reg;
        ext_next = ext_reg;
        rd_addr_next = rd_addr_reg;
        wr_addr_next = wr_addr_reg;
        done_next = '0;
        start = pkt_enable & ~act_reg;
        for (int i = 0; i < NCHAN; i++) begin
            cnt_next[i] = cnt_reg[i];
            src_next[i] = src_reg[i];
            dst_next[i] = dst_reg[i];
            // zero count load: a zero count behaves as one transfer
            if (start[i]) begin
                cnt_next[i] = (pkt_count[i*CNT_W +: CNT_W] == CNT_ZERO) ? CNT_W'(1) : pkt_count[i*CNT_W +: CNT_W];
                src_next[i] = pkt_src[i*ADDR_W +: ADDR_W];
                dst_next[i] = pkt_dst[i*ADDR_W +: ADDR_W];
            end
        end
        // mode gate: the other mode never starts a packet
        if (buffer_mode_select_setting == MODE_SEL_SUPPORTED) begin
            act_next = act_reg | start;
        end
        f_in_valid = (st_reg == DTC_READ) && rd_ack;
        f_out_ready = (st_reg == DTC_WRITE) && wr_ack;
        unique case (st_reg)
            DTC_IDLE: begin
                // halt and stop both just hold off new bursts here
                if (!halt && !stop && pick_ok) begin
                    // chaining extra: previous channel keeps one more transfer
                    if (extra_reg && act_reg[ch_reg]) begin
                        ch_next = ch_reg;
                        burst_next = (SW_W+1)'(1);
                        ext_next = 1'b1;
                    end else begin
                        ch_next = pick;
                        ext_next = 1'b0;
                        // switch size: burst from per-bus decode
                        burst_next = burst_len(pkt_switch[pick*SW_W +: SW_W], pkt_exp_bus[pick]);
                    end
                    extra_next = 1'b0;
                    st_next = DTC_READ;
                end
            end
            DTC_READ: begin
                if (rd_ack && f_in_ready) begin
                    st_next = DTC_WRITE;
                end
            end
            DTC_WRITE: begin
                if (wr_ack) begin
                    // count down: finish packet at zero
                    cnt_next[ch_reg] = CNT_W'(cnt_reg[ch_reg] - 1'b1);
                    burst_next = (SW_W+1)'(burst_reg - 1'b1);
                    rd_addr_next = ADDR_W'(rd_addr_reg + 1'b1);
                    wr_addr_next = ADDR_W'(wr_addr_reg + 1'b1);
                    src_next[ch_reg] = ADDR_W'(src_reg[ch_reg] + 1'b1);
                    dst_next[ch_reg] = ADDR_W'(dst_reg[ch_reg] + 1'b1);
                    if (cnt_reg[ch_reg] == CNT_W'(1)) begin
                        act_next[ch_reg] = 1'b0;
                        done_next[ch_reg] = 1'b1;
                        // a finished packet has nothing left to chain, so no stale extra survives
                        extra_next = 1'b0;
                        st_next = DTC_IDLE;
                    end else if (burst_reg == (SW_W+1)'(1)) begin
                        // the extra burst itself earns no further extra
                        extra_next = pkt_chain[ch_reg] && !ext_reg;
                        st_next = DTC_IDLE;
                    end else begin
                        st_next = DTC_READ;
                    end
                end
            end
        endcase
        // every burst starts from the chosen channel's own pointers
        if (st_reg == DTC_IDLE && st_next == DTC_READ) begin
            rd_addr_next = src_reg[ch_next];
            wr_addr_next = dst_reg[ch_next];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            st_reg <= DTC_IDLE;
            ch_reg <= '1;
            act_reg <= '0;
            burst_reg <= '0;
            extra_reg <= 1'b0;
            ext_reg <= 1'b0;
            rd_addr_reg <= '0;
            wr_addr_reg <= '0;
            done_reg <= '0;
            for (int i = 0; i < NCHAN; i++) begin
                cnt_reg[i] <= CNT_ZERO;
                src_reg[i] <= '0;
                dst_reg[i] <= '0;
            end
        end else begin
            st_reg <= st_next;
            ch_reg <= ch_next;
            act_reg <= act_next;
            burst_reg <= burst_next;
            extra_reg <= extra_next;
            rd_addr_reg <= rd_addr_next;
            wr_addr_reg <= wr_addr_next;
            done_reg <= done_next;
            cnt_reg <= cnt_next;
            src_reg <= src_next;
            dst_reg <= dst_next;
            ext_reg <= ext_next;
        end
    end

    // strobes registered so rd_req, wr_req, wr_cs and busy each leave a flip-flop
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rd_req_reg <= 1'b0;
            wr_req_reg <= 1'b0;
            wr_cs_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            rd_req_reg <= (st_next == DTC_READ);
            wr_req_reg <= (st_next == DTC_WRITE);
            // chip select block: read-only target gets no select
            wr_cs_reg <= (st_next == DTC_WRITE) && !dst_read_only;
            busy_reg <= (act_next != '0);
        end
    end

    assign rd_req = rd_req_reg;
    assign wr_req = wr_req_reg;
    assign wr_cs = wr_cs_reg;
    assign rd_addr = rd_addr_reg;
    assign wr_addr = wr_addr_reg;
    assign wr_data = f_out_data;
    assign busy = busy_reg;
    assign pkt_done = done_reg;
    // no illegal flag: blocked writes stay silent
    assign illegal_access = 1'b0;
    // no bounds abort: unmapped expansion targets pass
    assign abort = 1'b0;

    // check: a read-only write never carries a chip select
    a_ro_cs_blocked: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_reg == DTC_WRITE && dst_read_only) |=> !wr_cs) else $error("read-only write selected");
    a_mode_no_start: assert property (@(posedge mclk) disable iff (!rst_b)
        (buffer_mode_select_setting != MODE_SEL_SUPPORTED && act_reg == '0) |=> act_reg == '0)
        else $error("packet started in unsupported mode");
    a_zero_count_one: assert property (@(posedge mclk) disable iff (!rst_b)
        (start[0] && buffer_mode_select_setting == MODE_SEL_SUPPORTED && pkt_count[CNT_W-1:0] == CNT_ZERO)
        |=> cnt_reg[0] == CNT_W'(1)) else $error("zero count not loaded as one");
    a_count_dec: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_reg == DTC_WRITE && wr_ack && ch_reg == '0 && !start[0]) |=> cnt_reg[0] == CNT_W'($past(cnt_reg[0]) - 1'b1))
        else $error("count did not decrement");
    a_abort_quiet: assert property (@(posedge mclk) disable iff (!rst_b)
        !abort && !illegal_access) else $error("exception raised");
    a_burst_cpu_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_reg == DTC_IDLE && st_next == DTC_READ && !extra_reg && !pkt_exp_bus[pick]
         && pkt_switch[pick*SW_W +: SW_W] == SW_ZERO) |=> burst_reg == (SW_W+1)'(1))
        else $error("cpu bus zero switch not one");
    a_burst_exp: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_reg == DTC_IDLE && st_next == DTC_READ && !extra_reg && pkt_exp_bus[pick])
        |=> burst_reg == {1'b0, $past(pkt_switch[pick*SW_W +: SW_W])} + 1'b1)
        else $error("expansion burst wrong");
    a_chain_extra: assert property (@(posedge mclk) disable iff (!rst_b)
        (st_reg == DTC_IDLE && st_next == DTC_READ && extra_reg && act_reg[ch_reg]) |=> ch_reg == $past(ch_reg))
        else $error("chaining extra transfer skipped");
    a_done_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
        pkt_done[0] |=> !pkt_done[0]) else $error("done longer than a cycle");

    c_one_xfer: cover property (@(posedge mclk) disable iff (!rst_b) pkt_done[0]);
    c_ro_write: cover property (@(posedge mclk) disable iff (!rst_b) wr_req && !wr_cs);
    c_chain: cover property (@(posedge mclk) disable iff (!rst_b) extra_reg && st_reg == DTC_IDLE);
    c_fifo_full: cover property (@(posedge mclk) disable iff (!rst_b) !f_in_ready);
endmodule // dtc_ctrl

// *** dtc_pkg.sv ***
package dtc_pkg;
    // buffer mode select: only the zero setting is supported
    localparam logic MODE_SEL_SUPPORTED = 1'b0;
    localparam int CNT_W = 16;
    localparam int SW_W = 4;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int FIFO_DEPTH = 4;
    localparam int NCH = 2;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [SW_W-1:0] SW_ZERO = 4'h0;
    typedef enum logic [1:0] {DTC_IDLE, DTC_READ, DTC_WRITE} dtc_state_t;
endpackage

// *** dtc_fifo.sv ***
`timescale 1ns/1ps
module dtc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    // occupancy and pointers; full and empty come straight from the count
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_next = push ? AW'(wp_reg + 1'b1) : wp_reg;
        rp_next = pop ? AW'(rp_reg + 1'b1) : rp_reg;
        cnt_next = (AW+1)'(cnt_reg + (AW+1)'(push) - (AW+1)'(pop));
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    // storage has no reset, it is qualified by the count
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rp_reg];
endmodule // dtc_fifo

// *** dtc_mem_model.sv ***
`timescale 1ns/1ps
module dtc_mem_model
    import dtc_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic slow,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic rd_ack,
    output logic [DATA_W-1:0] rd_data,
    input wire logic wr_req,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_cs,
    output logic wr_ack,
    output int n_wr,
    output int n_cs,
    output logic [ADDR_W-1:0] last_addr,
    output logic [DATA_W-1:0] last_data
);
    int rd_wait;
    int wr_wait;
    // answers after 0 or 3 waits; read data flips outside acks so stale values never look right
    // any address answers, bounds unchecked
    // never reads packet or protection state
    always @(posedge mclk) begin
        if (!rst_b) begin
            rd_ack <= 1'b0;
            wr_ack <= 1'b0;
            rd_data <= 32'h0000_0000;
            rd_wait <= 0;
            wr_wait <= 0;
            n_wr <= 0;
            n_cs <= 0;
        end else begin
            rd_ack <= 1'b0;
            wr_ack <= 1'b0;
            rd_data <= ~rd_data;
            if (rd_req && !rd_ack) begin
                rd_wait <= rd_wait + 1;
                if (rd_wait >= (slow ? 3 : 0)) begin
                    rd_ack <= 1'b1;
                    rd_data <= {8'hA5, rd_addr};
                    rd_wait <= 0;
                end
            end
            if (wr_req && !wr_ack) begin
                wr_wait <= wr_wait + 1;
                if (wr_wait >= (slow ? 3 : 0)) begin
                    wr_ack <= 1'b1;
                    wr_wait <= 0;
                    n_wr <= n_wr + 1;
                    n_cs <= n_cs + (wr_cs ? 1 : 0);
                    last_addr <= wr_addr;
                    last_data <= wr_data;
                end
            end
        end
    end
endmodule // dtc_mem_model

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import dtc_pkg::*;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [NCH-1:0] pkt_enable = '0, pkt_request = '0, pkt_chain = '0, pkt_exp_bus = '0, pkt_done;
    logic [NCH*CNT_W-1:0] pkt_count = '0;
    logic [NCH*SW_W-1:0] pkt_switch = '0;
    logic [NCH*ADDR_W-1:0] pkt_src = '0, pkt_dst = '0;
    logic mode = 1'b0, halt = 1'b0, stop = 1'b0, slow = 1'b0, ro = 1'b0;
    logic rd_req, rd_ack, wr_req, wr_cs, wr_ack, illegal_access, abort, busy;
    logic [ADDR_W-1:0] rd_addr, wr_addr, last_addr;
    logic [DATA_W-1:0] rd_data, wr_data, last_data;
    int n_wr, n_cs, failures = 0, checked = 0, cycles = 0;
    dtc_ctrl dtc_ctrl_inst (.mclk(mclk), .rst_b(rst_b), .pkt_enable(pkt_enable), .pkt_request(pkt_request),
        .pkt_chain(pkt_chain), .pkt_exp_bus(pkt_exp_bus), .pkt_count(pkt_count), .pkt_switch(pkt_switch),
        .pkt_src(pkt_src), .pkt_dst(pkt_dst), .buffer_mode_select_setting(mode), .halt(halt), .stop(stop),
        .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_cs(wr_cs), .wr_ack(wr_ack), .dst_read_only(ro),
        .illegal_access(illegal_access), .abort(abort), .busy(busy), .pkt_done(pkt_done));
    dtc_mem_model dtc_mem_model_inst (.mclk(mclk), .rst_b(rst_b), .slow(slow), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .wr_req(wr_req), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_cs(wr_cs), .wr_ack(wr_ack), .n_wr(n_wr), .n_cs(n_cs),
        .last_addr(last_addr), .last_data(last_data));
    // clock at 40 MHz
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // hang guard: all tests finish well inside this ceiling
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    // one packet; hold 1 keeps halt up, 2 keeps stop up for a while first
    task automatic run_pkt(input int ch, input logic [15:0] cnt, input logic [3:0] sw, input logic exp,
        input logic [23:0] src, input logic [23:0] dst, input int hold);
        int n, k, w0, c0;
        n = (cnt == CNT_ZERO) ? 1 : int'(cnt);
        tick(1);
        w0 = n_wr;
        c0 = n_cs;
        halt = (hold == 1);
        stop = (hold == 2);
        pkt_count[ch*CNT_W +: CNT_W] = cnt;
        pkt_switch[ch*SW_W +: SW_W] = sw;
        pkt_src[ch*ADDR_W +: ADDR_W] = src;
        pkt_dst[ch*ADDR_W +: ADDR_W] = dst;
        pkt_exp_bus[ch] = exp;
        pkt_enable[ch] = 1'b1;
        pkt_request[ch] = 1'b1;
        if (hold != 0) begin
            tick(20);
            chk("held writes", 0, n_wr - w0);
            halt = 1'b0;
            stop = 1'b0;
        end
        k = 0;
        while (pkt_done[ch] !== 1'b1 && k < 600) begin
            tick(1);
            k++;
        end
        pkt_enable[ch] = 1'b0;
        pkt_request[ch] = 1'b0;
        chk("writes", n, n_wr - w0);
        chk("last addr", dst + n - 1, last_addr);
        chk("last data", {8'hA5, src + 24'(n - 1)}, last_data);
        chk("chip selects", ro ? 0 : n, n_cs - c0);
        chk("flags", 0, {illegal_access, abort});
        tick(2);
        chk("busy", 0, busy);
        $display("test packet ch%0d count %0d done", ch, cnt);
    endtask
    task automatic t_mode();
        int w0;
        w0 = n_wr;
        mode = 1'b1;
        pkt_enable[0] = 1'b1;
        pkt_request[0] = 1'b1;
        tick(30);
        chk("mode1 writes", 0, n_wr - w0);
        chk("mode1 busy", 0, busy);
        pkt_enable[0] = 1'b0;
        pkt_request[0] = 1'b0;
        mode = MODE_SEL_SUPPORTED;
        $display("test mode select done");
    endtask
    // ch1 chained with bursts of two; ch0 asks after ch1's first write and must wait one extra transfer
    task automatic t_chain();
        int w0, k;
        logic [NCH-1:0] seen;
        logic [ADDR_W-1:0] a3, a4;
        w0 = n_wr;
        k = 0;
        seen = '0;
        a3 = '0;
        a4 = '0;
        pkt_count = {16'h0004, 16'h0001};
        pkt_switch = {4'h2, SW_ZERO};
        pkt_src = {24'h000600, 24'h000500};
        pkt_dst = {24'h000C00, 24'h000D00};
        pkt_exp_bus = '0;
        pkt_chain = 2'b10;
        pkt_enable = 2'b11;
        pkt_request = 2'b10;
        while (seen != 2'b11 && k < 600) begin
            tick(1);
            k++;
            seen = seen | pkt_done;
            // a finished channel drops enable before the next edge so it does not restart
            pkt_enable = pkt_enable & ~pkt_done;
            pkt_request = pkt_request & ~pkt_done;
            if (n_wr - w0 == 1) begin
                pkt_request[0] = 1'b1;
            end
            if (n_wr - w0 == 3) begin
                a3 = last_addr;
            end
            if (n_wr - w0 == 4) begin
                a4 = last_addr;
            end
        end
        pkt_enable = '0;
        pkt_request = '0;
        pkt_chain = '0;
        chk("chain writes", 5, n_wr - w0);
        chk("third write addr", 24'h000C02, a3);
        chk("fourth write addr", 24'h000D00, a4);
        chk("chain last addr", 24'h000C03, last_addr);
        chk("chain last data", {8'hA5, 24'h000603}, last_data);
        $display("test chaining done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        tick(16);
        rst_b = 1'b1;
        tick(2);
        run_pkt(0, 16'h0003, SW_ZERO, 1'b0, 24'h000100, 24'h000800, 0);
        run_pkt(0, CNT_ZERO, 4'h2, 1'b0, 24'h000200, 24'h000900, 0);
        slow = 1'b1;
        ro = 1'b1;
        run_pkt(1, 16'h0005, 4'h1, 1'b1, 24'hFFFF00, 24'hFFFFF0, 0);
        ro = 1'b0;
        run_pkt(1, 16'h0002, 4'hF, 1'b1, 24'h000300, 24'h000A00, 1);
        slow = 1'b0;
        run_pkt(0, 16'h0002, 4'h1, 1'b0, 24'h000400, 24'h000B00, 2);
        t_chain();
        t_mode();
        tally_and_finish();
    end
endmodule // testbench
